// File: hdl/uart_timing_pkg.sv
// shared constants and state encodings for the uart status timing block
package uart_timing_pkg;
  localparam int          CLK_PERIOD_NS   = 8;      // core_clk period
  localparam int          DIV_W           = 16;     // baud divisor width
  localparam logic [15:0] DIV_RESET       = 16'h0001; // default divisor
  localparam int          OVERSAMPLE      = 16;     // baud ticks per bit
  localparam logic [3:0]  TICK_LAST       = 4'hf;   // last tick of a bit
  localparam logic [3:0]  TICK_MID        = 4'h7;   // mid-bit sample tick
  localparam logic [2:0]  BIT_LAST        = 3'h7;   // eighth data bit
  localparam int          TX_START_MIN    = 8;      // baud ticks, least
  localparam int          TX_START_MAX    = 24;     // baud ticks, most
  localparam logic [4:0]  TX_START_WAIT   = 5'h08;  // chosen wait in ticks
  localparam int          STROBE_GAP_P    = 4;      // host gap, clock periods
  localparam logic [2:0]  STROBE_GAP      = 3'h4;   // gap as a count
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;  // idle data value
  // serial engine states
  typedef enum logic [1:0] {
    LINE_IDLE,
    LINE_START,
    LINE_DATA,
    LINE_STOP
  } line_state_t;
endpackage : uart_timing_pkg

// File: hdl/baud_if.sv
// baud tick and divisor carrier between top and divider
`timescale 1ns/1ns
`default_nettype none
interface baud_if;
  logic [15:0] divisor;  // programmed divisor
  logic        tick;     // one-cycle pulse, 16x bit rate
  modport gen (input divisor, output tick);
  modport use_side (output divisor, input tick);
endinterface : baud_if
`default_nettype wire

// File: hdl/baud_divider.sv
// programmable baud tick generator at sixteen times the bit rate
`timescale 1ns/1ns
`default_nettype none
module baud_divider (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // tick carrier
  baud_if.gen       bif
);
  typedef struct packed {
    logic [15:0] count;  // cycles left in this tick period
    logic        tick;   // registered tick pulse
  } div_state_t;

  div_state_t st_reg;   // present state
  div_state_t st_next;  // next state

  // count down the divisor; a divisor of zero behaves as one
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.count <= 16'h0001) begin
      st_next.count = bif.divisor;
      st_next.tick  = 1'b1;
    end else begin
      st_next.count = st_reg.count - 16'h0001;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bif.tick = st_reg.tick;
endmodule : baud_divider
`default_nettype wire

// File: hdl/uart_status_timing.sv
// one uart channel: serial engines plus receive/transmit status timing
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - receive interrupt within one baud tick
// - tx start 8 to 24 ticks after clear
// - receive ready within one clock of stop
// - tx ready drops within 16 ticks
// - non-fifo holding register lags one tick
// - baud tick is sixteen times bit rate
// - fifo mode data readable immediately
module uart_status_timing #(
  parameter int DIV_W = uart_timing_pkg::DIV_W  // divisor width
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // configuration levels
  input  wire logic [DIV_W-1:0] baud_divisor,
  input  wire logic             fifo_mode,
  // host strobe port
  input  wire logic             read_strobe,
  input  wire logic             write_strobe,
  input  wire logic [7:0]       write_data,
  output logic [7:0]            rx_holding_reg,
  // status outputs
  output logic                  rx_data_avail,
  output logic                  tx_empty,
  output logic                  rx_irq,
  output logic                  tx_irq,
  output logic                  rx_ready_signal,
  output logic                  tx_ready_signal,
  // serial line
  input  wire logic             serial_in,
  output logic                  serial_out
);
  baud_if bif ();

  typedef struct packed {
    uart_timing_pkg::line_state_t rx_st;  // receiver state
    logic [3:0]  rx_tick;   // tick within bit
    logic [2:0]  rx_bit;    // data bit index
    logic [7:0]  rx_shift;  // incoming byte
    logic [7:0]  rx_hold;   // holding register value
    logic        rx_lag;    // non-fifo load pending
    logic        rx_avail;  // line status data bit
    logic        rx_irq;    // receive interrupt
    logic        rx_rdy;    // receive ready pin
    uart_timing_pkg::line_state_t tx_st;  // transmitter state
    logic [3:0]  tx_tick;   // tick within bit
    logic [2:0]  tx_bit;    // data bit index
    logic [7:0]  tx_shift;  // outgoing byte
    logic [7:0]  tx_hold;   // transmit holding register
    logic        tx_full;   // holding register loaded
    logic        tx_void;   // holding register empty, drives tx_empty
    logic        tx_irq;    // transmit interrupt
    logic        tx_rdy;    // transmit ready pin
    logic        tx_first;  // first clear of tx interrupt seen
    logic [4:0]  tx_wait;   // ticks since first clear
    logic        line;      // serial output level
    logic        rd_prev;   // read strobe last cycle
    logic        wr_prev;   // write strobe last cycle
  } chan_state_t;

  chan_state_t st_reg;   // present state
  chan_state_t st_next;  // next state
  logic        rd_edge;  // read strobe rising edge
  logic        wr_edge;  // write strobe rising edge

  assign bif.divisor = 16'(baud_divisor);

  baud_divider u_div (
    .core_clk (core_clk),
    .resetn   (resetn),
    .bif      (bif)
  );

  // the host keeps strobes four clocks apart, so edges never merge
  assign rd_edge = read_strobe & ~st_reg.rd_prev;
  assign wr_edge = write_strobe & ~st_reg.wr_prev;

  // next-state logic for both directions
  always_comb begin
    st_next         = st_reg;
    st_next.rd_prev = read_strobe;
    st_next.wr_prev = write_strobe;

    // host read clears receive status; a new stop in the same cycle wins
    if (rd_edge) begin
      st_next.rx_avail = 1'b0;
      st_next.rx_irq   = 1'b0;
      st_next.rx_rdy   = 1'b0;
    end

    // host write loads the holding register, never the live shift register,
    // so a write during a frame cannot corrupt the bits on the line
    if (wr_edge) begin
      st_next.tx_hold  = write_data;
      st_next.tx_full  = 1'b1;
      st_next.tx_void  = 1'b0;
      st_next.tx_irq   = 1'b0;
      st_next.tx_first = 1'b1;
      st_next.tx_wait  = 5'h00;
    end

    // non-fifo lag: the load lands on the tick after status
    if (bif.tick && st_reg.rx_lag) begin
      st_next.rx_hold = st_reg.rx_shift;
      st_next.rx_lag  = 1'b0;
    end

    // receiver, sampled mid-bit on 16x ticks
    if (bif.tick) begin
      st_next.rx_tick = st_reg.rx_tick + 4'h1;
      case (st_reg.rx_st)
        uart_timing_pkg::LINE_IDLE: begin
          st_next.rx_tick = 4'h0;
          if (!serial_in) begin
            st_next.rx_st = uart_timing_pkg::LINE_START;
          end
        end
        uart_timing_pkg::LINE_START: begin
          // false start is dropped at mid-bit
          if (st_reg.rx_tick == uart_timing_pkg::TICK_MID && serial_in) begin
            st_next.rx_st = uart_timing_pkg::LINE_IDLE;
          end else if (st_reg.rx_tick == uart_timing_pkg::TICK_LAST) begin
            st_next.rx_st  = uart_timing_pkg::LINE_DATA;
            st_next.rx_bit = 3'h0;
          end
        end
        uart_timing_pkg::LINE_DATA: begin
          if (st_reg.rx_tick == uart_timing_pkg::TICK_MID) begin
            st_next.rx_shift = {serial_in, st_reg.rx_shift[7:1]};
          end
          if (st_reg.rx_tick == uart_timing_pkg::TICK_LAST) begin
            st_next.rx_bit = st_reg.rx_bit + 3'h1;
            if (st_reg.rx_bit == uart_timing_pkg::BIT_LAST) begin
              st_next.rx_st = uart_timing_pkg::LINE_STOP;
            end
          end
        end
        uart_timing_pkg::LINE_STOP: begin
          // stop bit complete: status, interrupt and pin on this tick
          if (st_reg.rx_tick == uart_timing_pkg::TICK_LAST) begin
            st_next.rx_st    = uart_timing_pkg::LINE_IDLE;
            st_next.rx_avail = 1'b1;
            st_next.rx_irq   = 1'b1;
            st_next.rx_rdy   = 1'b1;
            if (fifo_mode) begin
              st_next.rx_hold = st_reg.rx_shift;
            end else begin
              st_next.rx_lag = 1'b1;
            end
          end
        end
        default: st_next.rx_st = uart_timing_pkg::LINE_IDLE;
      endcase
    end

    // transmitter
    if (bif.tick) begin
      st_next.tx_tick = st_reg.tx_tick + 4'h1;
      case (st_reg.tx_st)
        uart_timing_pkg::LINE_IDLE: begin
          st_next.tx_tick = 4'h0;
          st_next.line    = 1'b1;
          if (st_reg.tx_full) begin
            // hold off the start until the chosen 8-tick wait has run
            if (st_reg.tx_first &&
                st_reg.tx_wait < uart_timing_pkg::TX_START_WAIT) begin
              st_next.tx_wait = st_reg.tx_wait + 5'h01;
            end else begin
              st_next.tx_st    = uart_timing_pkg::LINE_START;
              st_next.line     = 1'b0;
              st_next.tx_first = 1'b0;
              st_next.tx_shift = st_reg.tx_hold;
              // a write landing on this tick refills the holding register
              st_next.tx_full  = wr_edge;
              st_next.tx_void  = ~wr_edge;
              st_next.tx_irq   = ~wr_edge;
              st_next.tx_rdy   = 1'b0;
            end
          end
        end
        uart_timing_pkg::LINE_START: begin
          if (st_reg.tx_tick == uart_timing_pkg::TICK_LAST) begin
            st_next.tx_st  = uart_timing_pkg::LINE_DATA;
            st_next.tx_bit = 3'h0;
            st_next.line   = st_reg.tx_shift[0];
          end
        end
        uart_timing_pkg::LINE_DATA: begin
          if (st_reg.tx_tick == uart_timing_pkg::TICK_LAST) begin
            st_next.tx_bit = st_reg.tx_bit + 3'h1;
            if (st_reg.tx_bit == uart_timing_pkg::BIT_LAST) begin
              st_next.tx_st = uart_timing_pkg::LINE_STOP;
              st_next.line  = 1'b1;
            end else begin
              st_next.line = st_reg.tx_shift[st_reg.tx_bit + 3'h1];
            end
          end
        end
        uart_timing_pkg::LINE_STOP: begin
          if (st_reg.tx_tick == uart_timing_pkg::TICK_LAST) begin
            st_next.tx_st  = uart_timing_pkg::LINE_IDLE;
            st_next.tx_rdy = ~st_next.tx_full;
          end
        end
        default: st_next.tx_st = uart_timing_pkg::LINE_IDLE;
      endcase
    end

    // a write while idle also drops ready at once
    if (wr_edge) begin
      st_next.tx_rdy = 1'b0;
    end
  end

  // state register; idle line high, transmitter ready, tx irq set
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg        <= '0;
      st_reg.line   <= 1'b1;
      st_reg.tx_rdy <= 1'b1;
      st_reg.tx_irq <= 1'b1;
      st_reg.tx_void <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs come straight from the state register
  assign rx_holding_reg  = st_reg.rx_hold;
  assign rx_data_avail   = st_reg.rx_avail;
  assign tx_empty        = st_reg.tx_void;
  assign rx_irq          = st_reg.rx_irq;
  assign tx_irq          = st_reg.tx_irq;
  assign rx_ready_signal = st_reg.rx_rdy;
  assign tx_ready_signal = st_reg.tx_rdy;
  assign serial_out      = st_reg.line;
endmodule : uart_status_timing
`default_nettype wire

// File: bench/uart_status_timing_checker.sv
// checker: timing relations between the status outputs and their causes
`timescale 1ns/1ns
`default_nettype none
module uart_status_timing_checker #(
  parameter int DIV_W = 16  // divisor width
) (
  // clock and reset
  input wire logic             core_clk,
  input wire logic             resetn,
  // configuration and host side
  input wire logic [DIV_W-1:0] baud_divisor,
  input wire logic             fifo_mode,
  input wire logic             read_strobe,
  input wire logic             write_strobe,
  input wire logic [7:0]       write_data,
  input wire logic [7:0]       rx_holding_reg,
  // status and serial
  input wire logic             rx_data_avail,
  input wire logic             tx_empty,
  input wire logic             rx_irq,
  input wire logic             tx_irq,
  input wire logic             rx_ready_signal,
  input wire logic             tx_ready_signal,
  input wire logic             serial_in,
  input wire logic             serial_out
);
  int   d;        // divisor in use, zero acts as one
  int   cnt_reg;  // cycles since the write strobe rose
  logic arm_reg;  // waiting for the first start bit
  logic ws_reg;   // last write strobe level
  logic so_reg;   // last serial out level
  assign d = (baud_divisor == '0) ? 1 : int'(baud_divisor);
  // start-bit watch, cleared at the first fall so data zeros are ignored
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 0;
      arm_reg <= 1'b0;
      ws_reg  <= 1'b0;
      so_reg  <= 1'b1;
    end else begin
      ws_reg  <= write_strobe;
      so_reg  <= serial_out;
      cnt_reg <= (write_strobe && !ws_reg) ? 0 : cnt_reg + 1;
      if (write_strobe && !ws_reg) begin
        arm_reg <= 1'b1;
      end else if (so_reg && !serial_out) begin
        arm_reg <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_rx_irq_status: assert property ($rose(rx_data_avail) |-> rx_irq)
    else $error("rx irq missing with data status");
  a_rx_ready_stop: assert property ($rose(rx_data_avail) |->
    rx_ready_signal && $past(serial_in))
    else $error("rx ready late after stop bit");
  a_tx_start_window: assert property (arm_reg && so_reg && !serial_out |->
    cnt_reg >= 8*d-1 && cnt_reg <= 24*d)
    else $error("tx start outside its window");
  a_tx_ready_drop: assert property ($rose(write_strobe) |->
    ##[1:2] !tx_ready_signal)
    else $error("tx ready did not drop");
  a_tx_irq_clear: assert property ($rose(write_strobe) |-> ##[1:2] !tx_irq)
    else $error("tx irq not cleared by write");
  a_read_clears_rx: assert property ($rose(read_strobe) |->
    ##[1:2] !rx_ready_signal)
    else $error("rx ready not cleared by read");
  a_fifo_no_lag: assert property (fifo_mode && rx_data_avail &&
    $past(rx_data_avail) |-> $stable(rx_holding_reg))
    else $error("holding reg moved after status in fifo mode");
  a_nonfifo_lag: assert property (!fifo_mode && $rose(rx_data_avail) |->
    $stable(rx_holding_reg))
    else $error("holding reg loaded with status in single mode");
  c_fifo_frame: cover property ($rose(rx_data_avail) && fifo_mode);
  c_single_frame: cover property ($rose(rx_data_avail) && !fifo_mode);
  c_tx_start: cover property (arm_reg && so_reg && !serial_out);
endmodule : uart_status_timing_checker
bind uart_status_timing uart_status_timing_checker #(.DIV_W(DIV_W)) chk (
  .core_clk(core_clk), .resetn(resetn), .baud_divisor(baud_divisor),
  .fifo_mode(fifo_mode), .read_strobe(read_strobe),
  .write_strobe(write_strobe), .write_data(write_data),
  .rx_holding_reg(rx_holding_reg), .rx_data_avail(rx_data_avail),
  .tx_empty(tx_empty), .rx_irq(rx_irq), .tx_irq(tx_irq),
  .rx_ready_signal(rx_ready_signal), .tx_ready_signal(tx_ready_signal),
  .serial_in(serial_in), .serial_out(serial_out));
`default_nettype wire

// File: bench/host_model.sv
// host model: spaced two-clock read and write strobes
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // requests from the bench
  input wire logic        wr_req,
  input wire logic        rd_req,
  input wire logic [7:0]  wr_byte,
  // strobe port
  output logic            write_strobe,
  output logic            read_strobe,
  output logic [7:0]      write_data
);
  logic [2:0] gap_reg;  // clocks left before the next strobe
  // requests during the gap are dropped, the bench never sends them
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gap_reg      <= 3'h0;
      write_strobe <= 1'b0;
      read_strobe  <= 1'b0;
      write_data   <= 8'h00;
    end else if (gap_reg != 3'h0) begin
      gap_reg <= gap_reg - 3'h1;
      if (gap_reg == 3'h3) begin
        write_strobe <= 1'b0;
        read_strobe  <= 1'b0;
      end
    end else if (wr_req) begin
      write_strobe <= 1'b1;
      write_data   <= wr_byte;
      gap_reg      <= uart_timing_pkg::STROBE_GAP;
    end else if (rd_req) begin
      read_strobe <= 1'b1;
      gap_reg     <= uart_timing_pkg::STROBE_GAP;
    end
  end
endmodule : host_model
`default_nettype wire

// File: bench/uart_status_timing_tb.sv
// testbench: looped-back frames judged on status timing
`timescale 1ns/1ns
`default_nettype none
module uart_status_timing_tb;
  logic        core_clk = 1'b0;          // 125 MHz
  logic        resetn = 1'b0;            // async, active low
  logic [15:0] baud_divisor = 16'h0002;  // clocks per tick
  logic        fifo_mode = 1'b1;
  logic        wr_req = 1'b0;
  logic        rd_req = 1'b0;
  logic [7:0]  wr_byte = 8'h00;
  logic        read_strobe, write_strobe, serial_line, rx_data_avail;
  logic        tx_empty, rx_irq, tx_irq, rx_ready_signal, tx_ready_signal;
  logic [7:0]  write_data, rx_holding_reg;
  logic [7:0]  last_byte = 8'h00;        // byte held before a frame
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cycles = 0;
  always #4 core_clk = ~core_clk;
  // serial out loops back to serial in
  uart_status_timing uut (.core_clk(core_clk), .resetn(resetn),
    .baud_divisor(baud_divisor), .fifo_mode(fifo_mode),
    .read_strobe(read_strobe), .write_strobe(write_strobe),
    .write_data(write_data), .rx_holding_reg(rx_holding_reg),
    .rx_data_avail(rx_data_avail), .tx_empty(tx_empty), .rx_irq(rx_irq),
    .tx_irq(tx_irq), .rx_ready_signal(rx_ready_signal),
    .tx_ready_signal(tx_ready_signal), .serial_in(serial_line),
    .serial_out(serial_line));
  host_model host (.core_clk(core_clk), .resetn(resetn), .wr_req(wr_req),
    .rd_req(rd_req), .wr_byte(wr_byte), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .write_data(write_data));
  task automatic check(input string name, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cyc
  // hang guard, a whole run is under two thousand clocks
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // one byte out and back; byte lsb must be 1 for the start width
  task automatic frame(input logic [7:0] b, input logic f);
    int t;
    int w;
    int d;
    @(posedge core_clk);
    // read after the edge so a divisor change just made has landed
    d = int'(baud_divisor);
    fifo_mode <= f;
    wr_byte   <= b;
    wr_req    <= 1'b1;
    @(posedge core_clk);
    wr_req <= 1'b0;
    wait_cyc(2);
    check("tx ready", 0, tx_ready_signal);
    check("tx irq", 0, tx_irq);
    check("tx empty", 0, tx_empty);
    t = 2;
    w = 0;
    do begin wait_cyc(1); t++; end while (serial_line && t < 1000);
    check("start window", 1, t >= 8*d && t <= 24*d);
    check("tx irq at start", 2'h3, {tx_irq, tx_empty});
    do begin wait_cyc(1); w++; end while (!serial_line && w < 1000);
    check("start width", 16*d, w);
    t = 0;
    while (!rx_data_avail && t < 400*d) begin wait_cyc(1); t++; end
    check("rx irq", 1, rx_irq);
    check("rx ready", 1, rx_ready_signal);
    check("tx ready back", 1, tx_ready_signal);
    check("holding at status", f ? b : last_byte, rx_holding_reg);
    if (!f) begin
      wait_cyc(d + 1);
      check("holding after tick", b, rx_holding_reg);
    end
    last_byte = b;
    @(posedge core_clk);
    rd_req <= 1'b1;
    @(posedge core_clk);
    rd_req <= 1'b0;
    wait_cyc(4);
    check("rx cleared", 0, {rx_data_avail, rx_irq, rx_ready_signal});
  endtask : frame
  task automatic test_reset;
    check("idle tx", 4'hf, {serial_line, tx_ready_signal, tx_irq, tx_empty});
    check("idle rx", 0, {rx_data_avail, rx_irq, rx_ready_signal});
    $display("test reset done");
  endtask : test_reset
  task automatic test_fifo;
    frame(8'ha5, 1'b1);
    $display("test fifo done");
  endtask : test_fifo
  task automatic test_single;
    frame(8'h3d, 1'b0);
    $display("test single done");
  endtask : test_single
  task automatic test_divisor;
    @(posedge core_clk);
    baud_divisor <= 16'h0003;
    frame(8'hc3, 1'b1);
    $display("test divisor done");
  endtask : test_divisor
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    wait_cyc(2);
    test_reset();
    test_fifo();
    test_single();
    test_divisor();
    finish_test();
  end
endmodule : uart_status_timing_tb
`default_nettype wire
